// File: design/nvpc_pkg.sv
// Constants and types for the nonvolatile program control block
package nvpc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [13:0] CTRL_IDX = 14'h0007;
    localparam logic [13:0] OPT_IDX = 14'h3DFE;
    localparam logic [13:0] EE_LO = 14'h0100;
    localparam logic [13:0] EE_HI = 14'h01FF;
    localparam logic [13:0] EPR_LO = 14'h0400;
    localparam logic [13:0] EPR_HI = 14'h3FFF;
    localparam logic [13:0] EPR_LAST = 14'h3FFF;

    // Control register fields
    localparam int CB_ELAT = 5;
    localparam int CB_EPGM = 4;
    localparam int CB_EERA = 2;
    localparam int CB_EELAT = 1;
    localparam int CB_PUMP = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Option register fields
    localparam int OB_POWER_ON_DELAY_SELECT = 4;
    localparam int OB_WATCHDOG_AFTER_RESET = 3;
    localparam int OB_WATCHDOG_IN_WAIT = 2;
    localparam int OB_PORT_B_PULLDOWN = 1;
    localparam int OB_PORT_C_PULLDOWN = 0;

    // Erased values
    localparam logic [7:0] EPROM_ERASED = 8'h00;
    localparam logic [7:0] EE_ERASED = 8'hFF;

    // Reset pin hold after power-on, in cycles
    localparam logic [11:0] TPORL_SHORT = 12'h010;
    localparam logic [11:0] TPORL_LONG = 12'hFE0;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [15:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } nvpc_av_req_t;

    // Register state of the control block; the EPROM and EEPROM arrays are kept apart
    typedef struct packed {
        logic wreq;
        logic [31:0] rdata;
        logic e_lat;
        logic e_pgm;
        logic e_burn;
        logic [7:0] e_valid;
        logic [10:0] e_page;
        logic [7:0][7:0] e_data;
        logic ee_lat;
        logic ee_era;
        logic ee_pump;
        logic ee_sel;
        logic [7:0] ee_addr;
        logic [7:0] ee_data;
        logic opt_done;
        logic [11:0] hold_cnt;
        logic hold;
        logic wd_armed;
        logic wd_en;
        logic [7:0] pd_b;
        logic [7:0] pd_c;
        logic er_busy;
        logic [13:0] er_addr;
        logic vec_ok;
    } nvpc_state_t;
endpackage

// File: design/nvpc_ctrl.sv
// EPROM and EEPROM program control with option register and bus slave
//
// Decided for this implementation: the Avalon-MM register port.

// Operation
// - Latch clear gives plain reads, clears program-enable
// - Latched EPROM reads do not return array contents
// - Stop mode returns EPROM to read mode
// - Erased EPROM bytes read as zero
// - Up to eight bytes, same upper address
// - Reprogramming only adds one bits
// - Latched, not programming: writes capture address, data
// - Stop and resets clear EPROM latch
// - Program-enable set needs latch and byte; no clear
// - EPROM latch/program pair decodes read, load, program
// - Erase-select picks erase or program while pumping
// - Erase-select frozen once address is latched
// - Latch without pump captures; no latch zeroes others
// - Stop and resets clear EEPROM latch
// - Pump settable after data, cleared only via latch
// - Three EEPROM bits decode read, load, program, erase
// - Power-on hold is 16 or 4064 cycles
// - Watchdog-after-reset option arms watchdog unless bootstrapping
// - Watchdog-in-wait option keeps watchdog counting
// - Port pull-downs only on input pins
module nvpc_ctrl (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Register bus
    input wire nvpc_pkg::nvpc_av_req_t av_req_i,
    output logic [31:0] av_readdata_o,
    output logic av_waitrequest_o,
    // Chip mode and supply
    input wire logic stop_i,
    input wire logic wait_i,
    input wire logic bootstrap_i,
    input wire logic wdog_start_i,
    input wire logic uv_erase_i,
    input wire logic eprom_program_supply_i,
    // Port directions
    input wire logic [7:0] ddr_b_i,
    input wire logic [7:0] ddr_c_i,
    // Status and controls out
    output logic reset_hold_o,
    output logic wdog_enable_o,
    output logic [7:0] port_b_pulldown_o,
    output logic [7:0] port_c_pulldown_o,
    output logic eprom_program_o,
    output logic eeprom_pump_o,
    output logic eprom_vectors_ok_o
);
    import nvpc_pkg::*;

    nvpc_state_t st_r;
    nvpc_state_t st_nxt;

    logic [7:0] eprom_mem [0:16383];
    logic [7:0] ee_mem [0:255];

    logic [13:0] idx;
    logic [7:0] wd;
    logic wr_go;
    logic rd_take;
    logic in_ee;
    logic in_epr;
    logic [7:0] rd_byte;
    logic [7:0] ctrl_byte;
    logic [7:0] opt;
    logic e_commit;
    logic ee_commit;

    always_comb begin
        idx = av_req_i.address[15:2];
        wd = av_req_i.writedata[7:0];
        in_ee = (idx >= EE_LO) && (idx <= EE_HI);
        in_epr = (idx >= EPR_LO) && (idx <= EPR_HI);
        opt = eprom_mem[OPT_IDX];
        wr_go = av_req_i.write && !st_r.wreq && av_req_i.byteenable[0];
        rd_take = av_req_i.read && st_r.wreq;
        ctrl_byte = {2'b00, st_r.e_lat, st_r.e_pgm, 1'b0,
                     st_r.ee_era, st_r.ee_lat, st_r.ee_pump};
        rd_byte = 8'h00;
        if (idx == CTRL_IDX) begin
            rd_byte = ctrl_byte;
        end else if (in_ee) begin
            rd_byte = ee_mem[idx[7:0]];
        end else if (in_epr) begin
            if (st_r.e_lat) begin
                rd_byte = st_r.e_data[idx[2:0]];
            end else begin
                rd_byte = eprom_mem[idx];
            end
        end

        st_nxt = st_r;
        st_nxt.wreq = !((av_req_i.read || av_req_i.write) && st_r.wreq);
        if (rd_take) begin
            st_nxt.rdata = {24'h000000, rd_byte};
        end

        if (wr_go && idx == CTRL_IDX) begin
            st_nxt.e_lat = wd[CB_ELAT];
            if (wd[CB_EPGM] && st_r.e_lat && (|st_r.e_valid)) begin
                st_nxt.e_pgm = 1'b1;
            end
            if (!wd[CB_ELAT]) begin
                st_nxt.e_pgm = 1'b0;
                st_nxt.e_valid = 8'h00;
                st_nxt.e_burn = 1'b0;
            end
            st_nxt.ee_lat = wd[CB_EELAT];
            if (wd[CB_EELAT] && !st_r.ee_sel) begin
                st_nxt.ee_era = wd[CB_EERA];
            end
            if (wd[CB_PUMP] && st_r.ee_lat && st_r.ee_sel) begin
                st_nxt.ee_pump = 1'b1;
            end
            if (!wd[CB_EELAT]) begin
                st_nxt.ee_era = 1'b0;
                st_nxt.ee_pump = 1'b0;
                st_nxt.ee_sel = 1'b0;
            end
        end else if (wr_go && in_ee && st_r.ee_lat && !st_r.ee_pump) begin
            st_nxt.ee_addr = idx[7:0];
            st_nxt.ee_data = wd;
            st_nxt.ee_sel = 1'b1;
        end else if (wr_go && in_epr && st_r.e_lat && !st_r.e_pgm) begin
            if (!(|st_r.e_valid) || idx[13:3] == st_r.e_page) begin
                st_nxt.e_page = idx[13:3];
                st_nxt.e_valid[idx[2:0]] = 1'b1;
                st_nxt.e_data[idx[2:0]] = wd;
            end
        end

        if (st_r.e_pgm && st_nxt.e_pgm && eprom_program_supply_i) begin
            st_nxt.e_burn = 1'b1;
        end

        if (stop_i) begin
            st_nxt.e_lat = 1'b0;
            st_nxt.e_pgm = 1'b0;
            st_nxt.e_burn = 1'b0;
            st_nxt.e_valid = 8'h00;
            st_nxt.ee_lat = 1'b0;
            st_nxt.ee_era = 1'b0;
            st_nxt.ee_pump = 1'b0;
            st_nxt.ee_sel = 1'b0;
        end

        st_nxt.vec_ok = !st_nxt.e_lat;
        e_commit = st_r.e_pgm && st_r.e_burn && !st_nxt.e_lat && !stop_i;
        ee_commit = st_r.ee_pump && !st_nxt.ee_lat && !stop_i;

        if (!st_r.opt_done) begin
            st_nxt.opt_done = 1'b1;
            st_nxt.hold_cnt = opt[OB_POWER_ON_DELAY_SELECT] ? TPORL_SHORT : TPORL_LONG;
            st_nxt.wd_armed = opt[OB_WATCHDOG_AFTER_RESET] && !bootstrap_i;
        end else if (st_r.hold_cnt != 12'h000) begin
            st_nxt.hold_cnt = st_r.hold_cnt - 12'h001;
        end
        st_nxt.hold = (st_nxt.hold_cnt != 12'h000);
        if (wdog_start_i) begin
            st_nxt.wd_armed = 1'b1;
        end
        st_nxt.wd_en = st_nxt.wd_armed && !(wait_i && !opt[OB_WATCHDOG_IN_WAIT]);
        st_nxt.pd_b = {8{opt[OB_PORT_B_PULLDOWN]}} & ~ddr_b_i;
        st_nxt.pd_c = {8{opt[OB_PORT_C_PULLDOWN]}} & ~ddr_c_i;

        if (st_r.er_busy) begin
            st_nxt.er_addr = st_r.er_addr + 14'h0001;
            if (st_r.er_addr == EPR_LAST) begin
                st_nxt.er_busy = 1'b0;
            end
        end else if (uv_erase_i) begin
            st_nxt.er_busy = 1'b1;
            st_nxt.er_addr = 14'h0000;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
            st_r.wreq <= 1'b1;
            st_r.hold <= 1'b1;
            st_r.vec_ok <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Nonvolatile arrays, untouched by reset
    always_ff @(posedge core_clk_i) begin
        if (st_r.er_busy) begin
            eprom_mem[st_r.er_addr] <= EPROM_ERASED;
        end else if (e_commit) begin
            for (int i = 0; i < 8; i++) begin
                if (st_r.e_valid[i]) begin
                    eprom_mem[{st_r.e_page, 3'(i)}] <=
                        eprom_mem[{st_r.e_page, 3'(i)}] | st_r.e_data[i];
                end
            end
        end
        if (ee_commit) begin
            ee_mem[st_r.ee_addr] <= st_r.ee_era ? EE_ERASED
                : (ee_mem[st_r.ee_addr] & st_r.ee_data);
        end
    end

    assign av_readdata_o = st_r.rdata;
    assign av_waitrequest_o = st_r.wreq;
    assign reset_hold_o = st_r.hold;
    assign wdog_enable_o = st_r.wd_en;
    assign port_b_pulldown_o = st_r.pd_b;
    assign port_c_pulldown_o = st_r.pd_c;
    assign eprom_program_o = st_r.e_pgm;
    assign eeprom_pump_o = st_r.ee_pump;
    assign eprom_vectors_ok_o = st_r.vec_ok;

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_bus_req;
        (av_req_i.read || av_req_i.write) && av_waitrequest_o;
    endsequence

    sequence s_bus_ack;
        !av_waitrequest_o ##1 av_waitrequest_o;
    endsequence

    sequence s_opt_load;
        rst_b_i && !st_r.opt_done && opt[OB_POWER_ON_DELAY_SELECT];
    endsequence

    a_bus_answer: assert property (s_bus_req |=> s_bus_ack)
        else $error("bus answer not one cycle after request");

    a_pgm_with_latch: assert property (st_r.e_pgm |-> st_r.e_lat)
        else $error("program enable without latch");

    a_pgm_set_cause: assert property ($rose(st_r.e_pgm) |->
        $past(st_r.e_lat) && $past(|st_r.e_valid))
        else $error("program enable set without latched byte");

    a_pgm_clear_path: assert property ($fell(st_r.e_pgm) |-> !st_r.e_lat)
        else $error("program enable cleared while latch stays");

    a_stop_clears: assert property (stop_i |=> !st_r.e_lat && !st_r.ee_lat)
        else $error("stop did not clear latches");

    a_ee_idle_zero: assert property (!st_r.ee_lat |-> !st_r.ee_era && !st_r.ee_pump)
        else $error("erase or pump set without latch");

    a_era_frozen: assert property (st_r.ee_sel ##1 st_r.ee_sel |-> $stable(st_r.ee_era))
        else $error("erase select changed after address latch");

    a_pump_needs_data: assert property ($rose(st_r.ee_pump) |-> $past(st_r.ee_sel))
        else $error("pump set before data selected");

    a_wait_wdog: assert property (st_r.opt_done && wait_i && !opt[OB_WATCHDOG_IN_WAIT]
        |=> !wdog_enable_o)
        else $error("watchdog running in wait mode");

    a_hold_short: assert property (s_opt_load |=>
        reset_hold_o [*8] ##1 reset_hold_o [*8] ##1 !reset_hold_o)
        else $error("short reset hold is not sixteen cycles");

    a_pulldown_input: assert property (st_r.opt_done |=>
        (port_b_pulldown_o & $past(ddr_b_i)) == 8'h00)
        else $error("pull-down on an output pin");

    a_pulldown_input_c: assert property (st_r.opt_done |=>
        (port_c_pulldown_o & $past(ddr_c_i)) == 8'h00)
        else $error("port c pull-down on an output pin");

    a_pulldown_b_on: assert property (st_r.opt_done && opt[OB_PORT_B_PULLDOWN] |=>
        port_b_pulldown_o == ~$past(ddr_b_i))
        else $error("port b pull-down missing on an input pin");

    a_ctrl_latch_write: assert property (wr_go && idx == CTRL_IDX && !stop_i |=>
        st_r.e_lat == $past(wd[CB_ELAT]))
        else $error("latch bit not taken from control write");

    a_pgm_no_clear: assert property (st_r.e_pgm && wr_go && idx == CTRL_IDX &&
        wd[CB_ELAT] && !stop_i |=> st_r.e_pgm)
        else $error("program enable cleared by software");

    a_pgm_latch_first: assert property (!st_r.e_lat |=> !st_r.e_pgm)
        else $error("program enable set without earlier latch");

    a_latched_read: assert property (rd_take && in_epr && st_r.e_lat |=>
        av_readdata_o[7:0] == $past(st_r.e_data[idx[2:0]]))
        else $error("latched read did not return latched byte");

    a_vectors_follow: assert property (eprom_vectors_ok_o == !st_r.e_lat)
        else $error("vector flag does not follow latch");

    a_stop_abandons: assert property (stop_i |=>
        !st_r.e_pgm && !st_r.e_burn && st_r.e_valid == 8'h00)
        else $error("stop left programming state");

    a_stop_ee_idle: assert property (stop_i |=>
        !eeprom_pump_o && !st_r.ee_era && !st_r.ee_sel)
        else $error("stop left eeprom state");

    a_page_share: assert property (wr_go && in_epr && (|st_r.e_valid) &&
        idx[13:3] != st_r.e_page && !stop_i |=> $stable(st_r.e_valid) && $stable(st_r.e_page))
        else $error("byte from another page latched");

    a_page_capture: assert property (wr_go && in_epr && st_r.e_lat && !st_r.e_pgm &&
        !stop_i && st_r.e_valid == 8'h00 |=>
        st_r.e_page == $past(idx[13:3]) && st_r.e_valid != 8'h00)
        else $error("first byte not captured");

    a_pgm_no_load: assert property (wr_go && in_epr && st_r.e_pgm && !stop_i |=>
        $stable(st_r.e_data) && $stable(st_r.e_valid))
        else $error("byte captured while programming");

    a_ee_load_blocked: assert property (wr_go && in_ee && st_r.ee_pump |=>
        $stable(st_r.ee_addr) && $stable(st_r.ee_data))
        else $error("eeprom capture while pump on");

    a_pump_clear_path: assert property ($fell(st_r.ee_pump) |-> !st_r.ee_lat)
        else $error("pump cleared while latch stays");

    a_pump_needs_sel: assert property (st_r.ee_pump |-> st_r.ee_lat && st_r.ee_sel)
        else $error("pump on without latched address");

    a_wdog_after_reset: assert property (rst_b_i && !st_r.opt_done &&
        opt[OB_WATCHDOG_AFTER_RESET] && !bootstrap_i && !wait_i |=> wdog_enable_o)
        else $error("watchdog not running after reset");

    a_wdog_boot_off: assert property (rst_b_i && !st_r.opt_done &&
        bootstrap_i && !wdog_start_i |=> !wdog_enable_o)
        else $error("watchdog running after bootstrap reset");

    a_hold_long_load: assert property (rst_b_i && !st_r.opt_done &&
        !opt[OB_POWER_ON_DELAY_SELECT] |=> st_r.hold_cnt == TPORL_LONG)
        else $error("long reset hold not loaded");

    a_hold_countdown: assert property (st_r.opt_done && st_r.hold_cnt != 12'h000 |=>
        st_r.hold_cnt == $past(st_r.hold_cnt) - 12'h001)
        else $error("reset hold count skipped");

    a_sweep_end: assert property (st_r.er_busy && st_r.er_addr == EPR_LAST |=>
        !st_r.er_busy)
        else $error("erase sweep did not stop at last byte");
endmodule

// File: tb/nvpc_ctrl_bench.sv
// Self-checking bench for the nonvolatile program control block
module nvpc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import nvpc_pkg::*;
    logic clk, rst_b, stop, wt, boot, wds, uv, sup;
    logic [7:0] ddr_b, ddr_c, pd_b, pd_c;
    nvpc_av_req_t req;
    logic [31:0] rdata, got;
    logic wreq, hold, wden, epgm, pump, vok;
    int n_mismatch = 0;
    int check_count = 0;

    nvpc_ctrl u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .av_req_i(req),
        .av_readdata_o(rdata), .av_waitrequest_o(wreq), .stop_i(stop), .wait_i(wt),
        .bootstrap_i(boot), .wdog_start_i(wds), .uv_erase_i(uv),
        .eprom_program_supply_i(sup), .ddr_b_i(ddr_b), .ddr_c_i(ddr_c),
        .reset_hold_o(hold), .wdog_enable_o(wden), .port_b_pulldown_o(pd_b),
        .port_c_pulldown_o(pd_c), .eprom_program_o(epgm), .eeprom_pump_o(pump),
        .eprom_vectors_ok_o(vok));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [7:0] b8(input logic b);
        return {7'h00, b};
    endfunction

    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic rd_n, input logic [13:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{read: rd_n, write: !rd_n, address: {idx, 2'b00},
                 writedata: {24'h000000, d}, byteenable: 4'hF};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        chk("answer", 8'h00, b8(wreq));
        got = rdata;
        req <= '0;
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        bus(1'b0, idx, d);
    endtask

    task automatic rd(input logic [13:0] idx, input logic [7:0] exp, input string what);
        bus(1'b1, idx, 8'h00);
        chk(what, exp, got[7:0]);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        cyc(16);
        chk("wait in reset", 8'h01, b8(wreq));
        rst_b <= 1'b1;
    endtask

    task automatic pulse_sup();
        @(posedge clk);
        sup <= 1'b1;
        cyc(2);
        sup <= 1'b0;
    endtask

    // Two bytes latched, program enabled, supply pulsed, latch cleared
    task automatic prog(input logic [13:0] a0, input logic [7:0] d0,
                        input logic [13:0] a1, input logic [7:0] d1);
        wr(CTRL_IDX, 8'h20);
        cyc(1);
        chk("vectors latched", 8'h00, b8(vok));
        wr(a0, d0);
        wr(a1, d1);
        wr(CTRL_IDX, 8'h30);
        wr(CTRL_IDX, 8'h20);
        rd(CTRL_IDX, 8'h30, "program kept");
        pulse_sup();
        wr(CTRL_IDX, 8'h00);
        cyc(1);
        chk("program cleared", 8'h00, b8(epgm));
        chk("vectors ok", 8'h01, b8(vok));
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        req = '0;
        rst_b = 1'b0;
        stop = 1'b0;
        wt = 1'b0;
        boot = 1'b0;
        wds = 1'b0;
        uv = 1'b0;
        sup = 1'b0;
        ddr_b = 8'h0F;
        ddr_c = 8'hA5;
        do_reset();
        @(posedge clk);
        uv <= 1'b1;
        @(posedge clk);
        uv <= 1'b0;
        cyc(16400);
        do_reset();
        cyc(4000);
        chk("long hold", 8'h01, b8(hold));
        cyc(100);
        chk("long hold end", 8'h00, b8(hold));
        chk("wdog off", 8'h00, b8(wden));
        chk("pull b off", 8'h00, pd_b);
        wds <= 1'b1;
        @(posedge clk);
        wds <= 1'b0;
        cyc(2);
        chk("wdog started", 8'h01, b8(wden));
        wt <= 1'b1;
        cyc(2);
        chk("wdog wait off", 8'h00, b8(wden));
        wt <= 1'b0;
        rd(CTRL_IDX, 8'h00, "ctrl reset");
        rd(EPR_LO, 8'h00, "erased");
        rd(14'h0002, 8'h00, "unmapped");
        wr(CTRL_IDX, 8'h20);
        wr(CTRL_IDX, 8'h30);
        rd(CTRL_IDX, 8'h20, "program no byte");
        wr(CTRL_IDX, 8'h00);
        prog(OPT_IDX, 8'h1F, EPR_LO, 8'hFF);
        rd(OPT_IDX, 8'h1F, "option");
        rd(EPR_LO, 8'h00, "other page");
        prog(EPR_LO, 8'h0F, EPR_LO + 14'h0007, 8'h80);
        prog(EPR_LO, 8'hF0, EPR_LO + 14'h0007, 8'h01);
        rd(EPR_LO, 8'hFF, "accumulate");
        rd(EPR_LO + 14'h0007, 8'h81, "page top");
        wr(CTRL_IDX, 8'h22);
        wr(EPR_LO + 14'h0001, 8'h55);
        rd(EPR_LO + 14'h0001, 8'h55, "latched read");
        wr(CTRL_IDX, 8'h32);
        wr(EPR_LO + 14'h0001, 8'hAA);
        rd(EPR_LO + 14'h0001, 8'h55, "no load in program");
        pulse_sup();
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        rd(CTRL_IDX, 8'h00, "stop clears");
        chk("stop program", 8'h00, b8(epgm));
        rd(EPR_LO + 14'h0001, 8'h00, "abandoned");
        wr(CTRL_IDX, 8'h05);
        rd(CTRL_IDX, 8'h00, "no latch");
        wr(CTRL_IDX, 8'h06);
        wr(CTRL_IDX, 8'h07);
        rd(CTRL_IDX, 8'h06, "pump before data");
        wr(EE_LO, 8'h00);
        wr(CTRL_IDX, 8'h03);
        rd(CTRL_IDX, 8'h07, "erase frozen");
        chk("pump on", 8'h01, b8(pump));
        wr(EE_LO + 14'h0001, 8'h11);
        wr(CTRL_IDX, 8'h06);
        rd(CTRL_IDX, 8'h07, "pump kept");
        wr(CTRL_IDX, 8'h00);
        rd(EE_LO, 8'hFF, "ee erase");
        wr(CTRL_IDX, 8'h02);
        wr(EE_LO, 8'h3C);
        wr(CTRL_IDX, 8'h03);
        rd(CTRL_IDX, 8'h03, "ee program");
        wr(CTRL_IDX, 8'h00);
        rd(EE_LO, 8'h3C, "ee data");
        boot <= 1'b1;
        do_reset();
        cyc(30);
        chk("wdog boot", 8'h00, b8(wden));
        boot <= 1'b0;
        do_reset();
        cyc(10);
        chk("short hold", 8'h01, b8(hold));
        cyc(20);
        chk("short hold end", 8'h00, b8(hold));
        chk("wdog armed", 8'h01, b8(wden));
        @(posedge clk);
        wt <= 1'b1;
        cyc(3);
        chk("wdog in wait", 8'h01, b8(wden));
        chk("pull b", 8'hF0, pd_b);
        chk("pull c", 8'h5A, pd_c);
        report_and_stop();
    end
endmodule
